/* File: include/pflash_prot_pkg.sv */
// shared constants and types for the program flash protection unit
`default_nettype none

package pflash_prot_pkg;

    // ---------------------------------------------------------------
    // register map: printed offsets are indices, byte address = 4*idx
    // ---------------------------------------------------------------
    localparam logic [7:0] STATUS_IDX = 8'h06;
    localparam logic [7:0] CONFIG_IDX = 8'h08;
    localparam logic [7:0] COMMAND_IDX = 8'h0c;
    localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
    localparam logic [9:0] CONFIG_ADDR = {CONFIG_IDX, 2'b00};
    localparam logic [9:0] COMMAND_ADDR = {COMMAND_IDX, 2'b00};

    // ---------------------------------------------------------------
    // protection config fields and values
    // ---------------------------------------------------------------
    localparam int OPEN_BIT = 7;
    localparam int RSV_BIT = 6;
    localparam int HDIS_BIT = 5;
    localparam int HSIZE_MSB = 4;
    localparam int HSIZE_LSB = 3;
    localparam int LDIS_BIT = 2;
    localparam int LSIZE_MSB = 1;
    localparam int LSIZE_LSB = 0;
    // open clear, every other bit set: whole array protected
    localparam logic [7:0] CONFIG_FULL = 8'h7f;
    localparam logic [7:0] CONFIG_RESET = CONFIG_FULL;

    // status fields
    localparam int VIOL_BIT = 4;
    localparam int LOADED_BIT = 0;

    // command word fields
    localparam int CMD_OP_MSB = 25;
    localparam int CMD_OP_LSB = 24;
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_PROGRAM = 2'h1;
    localparam logic [1:0] OP_SECTOR_ERASE = 2'h2;
    localparam logic [1:0] OP_BLOCK_ERASE = 2'h3;

    // ---------------------------------------------------------------
    // address map of the protected array
    // ---------------------------------------------------------------
    localparam logic [23:0] NV_CONFIG_ADDR = 24'hff_fe0c;
    localparam logic [23:0] PFLASH_TOP = 24'hff_ffff;
    localparam logic [23:0] PFLASH_LOW_BASE = 24'hff_8000;
    localparam logic [23:0] HIGH_START_2K = 24'hff_f800;
    localparam logic [23:0] HIGH_START_4K = 24'hff_f000;
    localparam logic [23:0] HIGH_START_8K = 24'hff_e000;
    localparam logic [23:0] HIGH_START_16K = 24'hff_c000;
    localparam logic [23:0] LOW_END_1K = 24'hff_83ff;
    localparam logic [23:0] LOW_END_2K = 24'hff_87ff;
    localparam logic [23:0] LOW_END_4K = 24'hff_8fff;
    localparam logic [23:0] LOW_END_8K = 24'hff_9fff;

    // ---------------------------------------------------------------
    // scenario index = {open, high disable, low disable}
    // allowed target mask per source scenario, bit n = target n
    // ---------------------------------------------------------------
    localparam logic [7:0][7:0] ALLOWED_MOVES = {
        8'hff, 8'h5a, 8'h3c, 8'h18, 8'h08, 8'h0c, 8'h0a, 8'h0f
    };

    // load sequencer states
    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } seq_state_type;

endpackage : pflash_prot_pkg

`default_nettype wire

/* File: src/pflash_addr_check.sv */
// address protection check against the current high and low windows
`timescale 1ns/100ps
`default_nettype none

module pflash_addr_check (
    input wire logic [7:0] config_byte,
    input wire logic [23:0] addr,
    input wire logic [1:0] op,
    output logic denied
);

    logic [23:0] high_start;
    logic [23:0] low_end;
    logic in_high;
    logic in_low;
    logic in_array;
    logic addr_prot;
    logic any_prot;

    // ---------------------------------------------------------------
    // window bounds from the size fields
    // ---------------------------------------------------------------
    always_comb begin
        unique case (config_byte[pflash_prot_pkg::HSIZE_MSB:
                                 pflash_prot_pkg::HSIZE_LSB])
            2'h0: high_start = pflash_prot_pkg::HIGH_START_2K; // [RQ10]
            2'h1: high_start = pflash_prot_pkg::HIGH_START_4K;
            2'h2: high_start = pflash_prot_pkg::HIGH_START_8K;
            2'h3: high_start = pflash_prot_pkg::HIGH_START_16K;
        endcase
        unique case (config_byte[pflash_prot_pkg::LSIZE_MSB:
                                 pflash_prot_pkg::LSIZE_LSB])
            2'h0: low_end = pflash_prot_pkg::LOW_END_1K; // [RQ13]
            2'h1: low_end = pflash_prot_pkg::LOW_END_2K;
            2'h2: low_end = pflash_prot_pkg::LOW_END_4K;
            2'h3: low_end = pflash_prot_pkg::LOW_END_8K;
        endcase
    end

    // both bounds compared on every check, with live register contents
    always_comb begin
        in_array = addr >= pflash_prot_pkg::PFLASH_LOW_BASE;
        in_high = !config_byte[pflash_prot_pkg::HDIS_BIT] &&
                  addr >= high_start; // [RQ9] [RQ22]
        in_low = !config_byte[pflash_prot_pkg::LDIS_BIT] && in_array &&
                 addr <= low_end; // [RQ12] [RQ22]
        if (config_byte[pflash_prot_pkg::OPEN_BIT]) begin
            addr_prot = in_high || in_low; // [RQ7]
            any_prot = !config_byte[pflash_prot_pkg::HDIS_BIT] ||
                       !config_byte[pflash_prot_pkg::LDIS_BIT];
        end else begin
            addr_prot = in_array && !(in_high || in_low); // [RQ8]
            // windows never cover the whole block, so something is locked
            any_prot = 1'b1;
        end
        unique case (op)
            pflash_prot_pkg::OP_BLOCK_ERASE: denied = any_prot; // [RQ17]
            pflash_prot_pkg::OP_NONE: denied = 1'b0;
            default: denied = addr_prot; // [RQ16]
        endcase
    end

endmodule : pflash_addr_check

`default_nettype wire

/* File: src/pflash_protection_unit.sv */
// program flash protection unit with ahb-lite register access
// Function
// [RQ1] at reset, load config from the nonvolatile protection byte
// [RQ2] double fault during that load gives full protection
// [RQ3] normal mode writes may only enlarge the protected region
// [RQ4] special mode writes all non-reserved bits freely; the code still writes sizes only while their disable bit is set
// [RQ5] normal mode write to a disallowed scenario is dropped whole
// [RQ6] allowed scenario moves follow the fixed transition table
// [RQ7] open set: cleared disable bit protects its window
// [RQ8] open clear: cleared disable bit unprotects its window only
// [RQ9] high disable bit enables the top-ending window when zero
// [RQ10] high size selects 2, 4, 8 or 16 KB at the top
// [RQ11] high size writable only while high disable is set
// [RQ12] low disable bit enables the bottom-starting window when zero
// [RQ13] low size selects 1, 2, 4 or 8 KB at the bottom
// [RQ14] low size writable only while low disable is set
// [RQ15] software keeps reserved bit 6 erased
// [RQ16] program or erase into protected space sets the violation flag
// [RQ17] block erase refused while any sector is protected
// [RQ18] reading config returns the enforced scenario
// [RQ19] software unprotects the top sector before reprogramming the byte
// [RQ20] writing one clears the violation flag; set blocks new commands
// [RQ21] scenario index is open, high disable, low disable
// [RQ22] address check compares both bounds with current contents
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

module pflash_protection_unit (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic special_mode,
    input wire logic nv_load_valid,
    input wire logic [7:0] nv_load_byte,
    input wire logic nv_double_fault,
    output logic cmd_start,
    output logic [23:0] cmd_addr,
    output logic [1:0] cmd_op
);

    pflash_prot_pkg::seq_state_type state_q, state_d;
    logic [7:0] config_q, config_d;
    logic viol_q, viol_d;
    logic start_q, start_d;
    logic [23:0] addr_q, addr_d;
    logic [1:0] op_q, op_d;
    logic wr_q, wr_d;
    logic [9:0] waddr_q, waddr_d;
    logic [31:0] rdata_q, rdata_d;
    logic mode_meta_q, mode_sync_q;
    logic addr_phase;
    logic cfg_wr, stat_wr, cmd_wr;
    logic [7:0] cand;
    logic [2:0] from_scn, to_scn;
    logic launch, denied;

    // ---------------------------------------------------------------
    // mode pin synchroniser
    // ---------------------------------------------------------------
    // the pin is a strap from outside the clock domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_meta_q <= 1'b0;
            mode_sync_q <= 1'b0;
        end else begin
            mode_meta_q <= special_mode;
            mode_sync_q <= mode_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // ---------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign addr_phase = hsel && htrans[1] && hready;
    assign cfg_wr = wr_q && waddr_q == pflash_prot_pkg::CONFIG_ADDR;
    assign stat_wr = wr_q && waddr_q == pflash_prot_pkg::STATUS_ADDR;
    assign cmd_wr = wr_q && waddr_q == pflash_prot_pkg::COMMAND_ADDR;

    // read data uses next values so a read right after a write sees it
    always_comb begin
        wr_d = addr_phase && hwrite;
        waddr_d = haddr[9:0];
        rdata_d = rdata_q;
        if (addr_phase && !hwrite) begin
            rdata_d = 32'h0000_0000;
            unique case (haddr[9:0])
                pflash_prot_pkg::CONFIG_ADDR:
                    rdata_d[7:0] = config_d; // [RQ18]
                pflash_prot_pkg::STATUS_ADDR: begin
                    rdata_d[pflash_prot_pkg::VIOL_BIT] = viol_d;
                    rdata_d[pflash_prot_pkg::LOADED_BIT] =
                        state_d == pflash_prot_pkg::ST_RUN;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            waddr_q <= 10'h000;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_q <= wr_d;
            waddr_q <= waddr_d;
            rdata_q <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // reset load sequencer and protection config
    // ---------------------------------------------------------------
    // candidate value: disable and open bits always, sizes only when
    // the current disable bit is set; reserved bit never by software
    always_comb begin
        cand = config_q;
        cand[pflash_prot_pkg::OPEN_BIT] = hwdata[pflash_prot_pkg::OPEN_BIT];
        cand[pflash_prot_pkg::HDIS_BIT] = hwdata[pflash_prot_pkg::HDIS_BIT];
        cand[pflash_prot_pkg::LDIS_BIT] = hwdata[pflash_prot_pkg::LDIS_BIT];
        if (config_q[pflash_prot_pkg::HDIS_BIT]) begin
            cand[4:3] = hwdata[4:3]; // [RQ11]
        end
        if (config_q[pflash_prot_pkg::LDIS_BIT]) begin
            cand[1:0] = hwdata[1:0]; // [RQ14]
        end
        from_scn = {config_q[7], config_q[5], config_q[2]}; // [RQ21]
        to_scn = {cand[7], cand[5], cand[2]};
    end

    always_comb begin
        state_d = state_q;
        config_d = config_q;
        unique case (state_q)
            pflash_prot_pkg::ST_LOAD: begin
                if (nv_load_valid) begin
                    state_d = pflash_prot_pkg::ST_RUN;
                    if (nv_double_fault) begin
                        config_d = pflash_prot_pkg::CONFIG_FULL; // [RQ2]
                    end else begin
                        config_d = nv_load_byte; // [RQ1]
                    end
                end
            end
            pflash_prot_pkg::ST_RUN: begin
                if (cfg_wr) begin
                    if (mode_sync_q) begin
                        config_d = cand; // [RQ4]
                    end else if (ALLOWED_HIT(from_scn, to_scn)) begin
                        config_d = cand; // [RQ3] [RQ6]
                    end // else dropped whole [RQ5]
                end
            end
            default: state_d = pflash_prot_pkg::ST_LOAD;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= pflash_prot_pkg::ST_LOAD;
            config_q <= pflash_prot_pkg::CONFIG_RESET;
        end else begin
            state_q <= state_d;
            config_q <= config_d;
        end
    end

    function automatic logic ALLOWED_HIT(input logic [2:0] from_i,
                                         input logic [2:0] to_i);
        ALLOWED_HIT = pflash_prot_pkg::ALLOWED_MOVES[from_i][to_i];
    endfunction : ALLOWED_HIT

    // ---------------------------------------------------------------
    // command check, launch and violation flag
    // ---------------------------------------------------------------
    pflash_addr_check u_check (
        .config_byte(config_q),
        .addr(hwdata[23:0]),
        .op(hwdata[pflash_prot_pkg::CMD_OP_MSB:pflash_prot_pkg::CMD_OP_LSB]),
        .denied(denied)
    );

    // a set flag blocks every new launch until software clears it
    assign launch = cmd_wr && state_q == pflash_prot_pkg::ST_RUN &&
                    !viol_q && hwdata[25:24] != pflash_prot_pkg::OP_NONE;

    always_comb begin
        viol_d = viol_q;
        start_d = 1'b0;
        addr_d = addr_q;
        op_d = op_q;
        if (stat_wr && hwdata[pflash_prot_pkg::VIOL_BIT]) begin
            viol_d = 1'b0; // [RQ20]
        end
        if (launch) begin
            if (denied) begin
                viol_d = 1'b1; // set wins over clear [RQ16] [RQ17]
            end else begin
                start_d = 1'b1;
                addr_d = hwdata[23:0];
                op_d = hwdata[25:24];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            viol_q <= 1'b0;
            start_q <= 1'b0;
            addr_q <= 24'h00_0000;
            op_q <= pflash_prot_pkg::OP_NONE;
        end else begin
            viol_q <= viol_d;
            start_q <= start_d;
            addr_q <= addr_d;
            op_q <= op_d;
        end
    end

    assign cmd_start = start_q;
    assign cmd_addr = addr_q;
    assign cmd_op = op_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_load_byte: assert property ( // [RQ1]
        state_q == pflash_prot_pkg::ST_LOAD && nv_load_valid &&
        !nv_double_fault |=> config_q == $past(nv_load_byte))
        else $error("config not loaded from nonvolatile byte");

    a_fault_full: assert property ( // [RQ2]
        state_q == pflash_prot_pkg::ST_LOAD && nv_load_valid &&
        nv_double_fault |=> config_q == 8'h7f)
        else $error("double fault did not give full protection");

    // judged on the cycle that made the change, so a load or a mode
    // switch one edge earlier cannot be mistaken for a software write
    a_normal_moves: assert property ( // [RQ5]
        $past(state_q) == pflash_prot_pkg::ST_RUN && !$past(mode_sync_q) &&
        config_q != $past(config_q) |->
        pflash_prot_pkg::ALLOWED_MOVES[{$past(config_q[7]),
            $past(config_q[5]), $past(config_q[2])}]
            [{config_q[7], config_q[5], config_q[2]}])
        else $error("disallowed scenario move in normal mode");

    // size bits may still move under full protection; the scenario not
    a_full_locked: assert property ( // [RQ6]
        state_q == pflash_prot_pkg::ST_RUN && !mode_sync_q &&
        {config_q[7], config_q[5], config_q[2]} == 3'h3 |=>
        {config_q[7], config_q[5], config_q[2]} == 3'h3)
        else $error("full protection left in normal mode");

    a_hsize_hold: assert property ( // [RQ11]
        state_q == pflash_prot_pkg::ST_RUN && !config_q[5] |=>
        config_q[4:3] == $past(config_q[4:3]))
        else $error("high size changed while window enabled");

    a_lsize_hold: assert property ( // [RQ14]
        state_q == pflash_prot_pkg::ST_RUN && !config_q[2] |=>
        config_q[1:0] == $past(config_q[1:0]))
        else $error("low size changed while window enabled");

    a_denied_flag: assert property ( // [RQ16]
        launch && denied |=> viol_q && !cmd_start)
        else $error("protected command not flagged");

    a_flag_blocks: assert property ( // [RQ20]
        viol_q && !stat_wr ##1 viol_q |-> !cmd_start)
        else $error("command started while violation flag set");

    a_flag_clear: assert property ( // [RQ20]
        stat_wr && hwdata[4] && !launch |=> !viol_q)
        else $error("violation flag not cleared by write of one");

    a_read_config: assert property ( // [RQ18]
        addr_phase && !hwrite && haddr[9:0] == pflash_prot_pkg::CONFIG_ADDR
        ##1 !cfg_wr |-> hrdata[7:0] == config_q && hrdata[31:8] == 24'h0)
        else $error("config read does not match enforced value");

endmodule : pflash_protection_unit

`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the program flash protection unit
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    // ------------------------------------------------------------
    // signals and constants
    // ------------------------------------------------------------
    localparam logic [1:0] PG = pflash_prot_pkg::OP_PROGRAM;
    localparam logic [1:0] SE = pflash_prot_pkg::OP_SECTOR_ERASE;
    localparam logic [1:0] BE = pflash_prot_pkg::OP_BLOCK_ERASE;
    localparam logic [9:0] CFG = pflash_prot_pkg::CONFIG_ADDR;
    localparam logic [9:0] STA = pflash_prot_pkg::STATUS_ADDR;
    // allowed target mask per source scenario, bit n = target n
    localparam logic [7:0] MOVES [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08,
                                        8'h18, 8'h3c, 8'h5a, 8'hff};
    typedef struct packed {
        logic [7:0] cfg;
        logic [1:0] op;
        logic [23:0] a;
        logic den;
    } crow_type;
    localparam crow_type CROWS [23] = '{
        '{8'h80, PG, 24'hff_f7ff, 1'b0}, '{8'h80, PG, 24'hff_f800, 1'b1},
        '{8'h80, SE, 24'hff_83ff, 1'b1}, '{8'h80, SE, 24'hff_8400, 1'b0},
        '{8'h80, BE, 24'hff_8000, 1'b1}, '{8'h8c, PG, 24'hff_efff, 1'b0},
        '{8'h8c, PG, 24'hff_f000, 1'b1}, '{8'h94, PG, 24'hff_dfff, 1'b0},
        '{8'h94, PG, 24'hff_e000, 1'b1}, '{8'h9c, PG, 24'hff_bfff, 1'b0},
        '{8'h9c, PG, 24'hff_c000, 1'b1}, '{8'ha3, PG, 24'hff_9fff, 1'b1},
        '{8'ha3, PG, 24'hff_a000, 1'b0}, '{8'ha2, SE, 24'hff_8fff, 1'b1},
        '{8'ha2, SE, 24'hff_9000, 1'b0}, '{8'ha4, BE, 24'hff_8000, 1'b0},
        '{8'h24, PG, 24'hff_a000, 1'b1}, '{8'h24, PG, 24'h7f_0000, 1'b0},
        '{8'h1c, PG, 24'hff_c000, 1'b0}, '{8'h1c, PG, 24'hff_bfff, 1'b1},
        '{8'h21, PG, 24'hff_87ff, 1'b0}, '{8'h21, PG, 24'hff_8800, 1'b1},
        '{8'h21, BE, 24'hff_8000, 1'b1}
    };
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic special_mode = 1'b0;
    logic nv_load_valid = 1'b0;
    logic [7:0] nv_load_byte = 8'h0;
    logic nv_double_fault = 1'b0;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic cmd_start;
    logic [23:0] cmd_addr;
    logic [1:0] cmd_op;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [2:0] s;
    logic [2:0] t;
    logic [7:0] r_from [64];
    logic [7:0] r_wr [64];
    logic [7:0] r_exp [64];

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    pflash_protection_unit i_pflash_protection_unit (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .special_mode(special_mode),
        .nv_load_valid(nv_load_valid),
        .nv_load_byte(nv_load_byte),
        .nv_double_fault(nv_double_fault),
        .cmd_start(cmd_start),
        .cmd_addr(cmd_addr),
        .cmd_op(cmd_op)
    );

    // 40 mhz clock
    initial begin
        forever #12.5 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // one ahb-lite single transfer, waits on hready in both phases
    task automatic bus(input logic wr, input logic [9:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp,
                          input string what);
        bus(1'b0, a, 32'h0);
        check(rd, exp, what);
    endtask : rd_chk

    // mode input passes a two stage synchroniser, so allow settling
    task automatic mode(input logic m);
        @(posedge hclk);
        special_mode <= m;
        repeat (4) @(posedge hclk);
    endtask : mode

    // size fields only take a write while disabled, so disable first
    task automatic set_cfg(input logic [7:0] v);
        bus(1'b1, CFG, 32'ha4);
        bus(1'b1, CFG, 32'ha4);
        bus(1'b1, CFG, {24'h0, v});
    endtask : set_cfg

    task automatic command(input logic [1:0] op, input logic [23:0] a,
                           input logic den);
        logic seen;
        seen = 1'b0;
        bus(1'b1, pflash_prot_pkg::COMMAND_ADDR, {6'h0, op, a});
        repeat (3) begin
            @(negedge hclk);
            if (cmd_start === 1'b1) seen = 1'b1;
        end
        check({31'h0, seen}, {31'h0, ~den}, "start");
        if (seen) begin
            check({6'h0, cmd_op, cmd_addr}, {6'h0, op, a}, "cmd");
        end
        rd_chk(STA, {27'h0, den, 4'h1}, "status");
    endtask : command

    task automatic do_reset(input logic [7:0] b, input logic f);
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        check(hrdata, 32'h0, "reset rdata");
        hresetn <= 1'b1;
        mode(1'b1);
        bus(1'b1, CFG, 32'he4);
        rd_chk(CFG, 32'h7f, "preload");
        @(posedge hclk);
        nv_load_valid <= 1'b1;
        nv_load_byte <= b;
        nv_double_fault <= f;
        @(posedge hclk);
        nv_load_valid <= 1'b0;
        nv_double_fault <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask : do_reset

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    // run should need a few thousand cycles; far beyond means a hang
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        // every scenario pair, sizes asking to grow both windows
        for (int i = 0; i < 64; i++) begin
            s = i[5:3];
            t = i[2:0];
            r_from[i] = {s[2], 1'b1, s[1], 2'b00, s[0], 2'b00};
            r_wr[i] = {t[2], 1'b0, t[1], 2'b11, t[0], 2'b11};
            r_exp[i] = MOVES[s][t] ?
                {t[2], 1'b1, t[1], {2{s[1]}}, t[0], {2{s[0]}}} : r_from[i];
        end
        do_reset(8'he4, 1'b1);
        rd_chk(CFG, 32'h7f, "fault load");
        rd_chk(STA, 32'h1, "loaded");
        do_reset(8'he4, 1'b0);
        rd_chk(CFG, 32'he4, "nv load");
        for (int i = 0; i < 64; i++) begin
            mode(1'b1);
            set_cfg(r_from[i]);
            rd_chk(CFG, {24'h0, r_from[i]}, "special");
            mode(1'b0);
            bus(1'b1, CFG, {24'h0, r_wr[i]});
            rd_chk(CFG, {24'h0, r_exp[i]}, "move");
            check({30'h0, hreadyout, hresp}, 32'h2, "okay");
        end
        // unmapped place reads zero and ignores writes
        bus(1'b1, 10'h3fc, 32'hffff_ffff);
        rd_chk(10'h3fc, 32'h0, "unmapped");
        mode(1'b1);
        foreach (CROWS[i]) begin
            set_cfg(CROWS[i].cfg);
            command(CROWS[i].op, CROWS[i].a, CROWS[i].den);
            if (CROWS[i].den) begin
                bus(1'b1, STA, 32'h10);
            end
        end
        // a set flag blocks launches; only a written one clears it
        set_cfg(8'h80);
        // an empty op neither launches nor flags, even at a protected place
        bus(1'b1, pflash_prot_pkg::COMMAND_ADDR, 32'h00ff_f800);
        rd_chk(STA, 32'h1, "no op");
        command(PG, 24'hff_f800, 1'b1);
        command(PG, 24'hff_0000, 1'b1);
        bus(1'b1, STA, 32'h0);
        rd_chk(STA, 32'h11, "keep flag");
        bus(1'b1, STA, 32'h10);
        rd_chk(STA, 32'h1, "clear flag");
        command(PG, 24'hff_0000, 1'b0);
        rd_chk(CFG, 32'hc0, "enforced");
        // the top sector holds the protection byte: unprotect it first
        command(PG, pflash_prot_pkg::NV_CONFIG_ADDR, 1'b1);
        bus(1'b1, STA, 32'h10);
        set_cfg(8'ha4);
        command(PG, pflash_prot_pkg::NV_CONFIG_ADDR, 1'b0);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
